// ---- verilog/usbep_pkg.sv ----
// Operation
// [RULE1] enable bit activates or deactivates endpoint
// [RULE2] endpoint zero enabled after any reset
// [RULE3] control bits 6..4 read zero, never written
// [RULE4] accepted DATA0 sets toggle status
// [RULE5] accepted DATA1 clears toggle status
// [RULE6] direction bit one is IN, zero OUT
// [RULE7] direction ignored on control endpoints
// [RULE8] type decode; endpoint zero always control
// [RULE9] endpoint zero control resets to 80h
// [RULE10] other endpoint controls reset to 00h
// [RULE11] control direction honoured only for control type
// [RULE12] firmware sets control direction only for IN
// [RULE13] ping-pong bank1 store sets bank1 flag
// [RULE14] bank1 flag set raises endpoint interrupt
// [RULE15] bank1 flag set NAKs further bank1 OUTs
// [RULE16] isochronous endpoints never NAK on bank1
// [RULE17] firmware clears bank1 flag after reading
// [RULE18] stall request makes next handshake STALL
// [RULE19] stall sent flag set, interrupt raised; isochronous endpoints ignore stall sent
// [RULE20] index register selects endpoint 0 to 6
// [RULE21] separate control and status per endpoint
// [RULE22] toggle status cleared on reset
package usbep_pkg;
	localparam int NUM_EP = 7;
	localparam logic [7:0] ADDR_INDEX = 8'hc7;
	localparam logic [7:0] ADDR_STATUS = 8'hce;
	localparam logic [7:0] ADDR_CONTROL = 8'hd4;
	localparam logic [7:0] CTRL_RESET_EP0 = 8'h80;
	localparam logic [7:0] CTRL_RESET_OTHER = 8'h00;
	localparam logic [7:0] CTRL_WRITE_MASK = 8'h87;
	localparam logic [7:0] STAT_WRITE_MASK = 8'hbf;
	localparam logic [2:0] MAX_INDEX = 3'h6;
	localparam logic [2:0] FIRST_PINGPONG = 3'h4;
	localparam int BIT_ENABLE = 7;
	localparam int BIT_TOGGLE = 3;
	localparam int BIT_DIR = 2;
	localparam int BIT_CTRL_DIR = 7;
	localparam int BIT_BANK1 = 6;
	localparam int BIT_STALL_REQUEST = 5;
	localparam int BIT_STALLSENT = 3;
	typedef enum logic [1:0] {
		USBEP_CONTROL = 2'h0,
		USBEP_ISO = 2'h1,
		USBEP_BULK = 2'h2,
		USBEP_INTR = 2'h3
	} usbep_type_t;
	// one event from the serial engine, addressed to an endpoint
	typedef struct packed {
		logic data0_ok;
		logic data1_ok;
		logic bank1_stored;
		logic stall_sent;
	} usbep_evt_t;
	// decoded per-endpoint view for the serial engine
	typedef struct packed {
		logic active;
		logic dir_in;
		logic ctrl_dir_in;
		logic nak_bank1;
		logic stall;
		usbep_type_t ep_type;
	} usbep_view_t;
endpackage : usbep_pkg

// ---- verilog/usbep_sync.sv ----
`timescale 1ns/1ns
// two-stage synchroniser for pin-level inputs
module usbep_sync import usbep_pkg::*; #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;
	// first stage feeds only the second
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta <= '0;
			q <= '0;
		end else if (ce) begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : usbep_sync

// ---- verilog/usbep_slot.sv ----
`timescale 1ns/1ns
// =========================================
// one endpoint's control and status state
module usbep_slot import usbep_pkg::*; #(
	parameter logic [2:0] EP = 3'h0
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic bus_reset,
	input wire logic wr_ctrl,
	input wire logic wr_stat,
	input wire logic [7:0] wdata,
	input wire usbep_evt_t evt,
	output logic [7:0] ctrl,
	output logic [7:0] stat,
	output usbep_view_t view,
	output logic irq_evt
);
	localparam logic [7:0] CTRL_RST = (EP == 3'h0) ? CTRL_RESET_EP0 : CTRL_RESET_OTHER; // [RULE9] [RULE10]
	localparam logic PINGPONG = (EP >= FIRST_PINGPONG);
	logic [7:0] next_ctrl;
	logic [7:0] next_stat;
	usbep_type_t eff_type;
	usbep_type_t next_type;

	// endpoint zero is forced to control type whatever was written
	assign eff_type = (EP == 3'h0) ? USBEP_CONTROL : usbep_type_t'(ctrl[1:0]); // [RULE8]
	// the view follows the type being written, so it never lags a control write by a cycle
	assign next_type = (EP == 3'h0) ? USBEP_CONTROL : usbep_type_t'(next_ctrl[1:0]); // [RULE8]

	always_comb begin
		next_ctrl = ctrl;
		if (wr_ctrl) begin
			next_ctrl = (wdata & CTRL_WRITE_MASK) | (ctrl & ~CTRL_WRITE_MASK); // [RULE3] [RULE1]
		end
		next_ctrl[6:4] = 3'h0; // [RULE3]
		// hardware events win over a firmware write in the same cycle
		if (evt.data0_ok) begin
			next_ctrl[BIT_TOGGLE] = 1'b1; // [RULE4]
		end else if (evt.data1_ok) begin
			next_ctrl[BIT_TOGGLE] = 1'b0; // [RULE5]
		end
	end

	always_comb begin
		next_stat = stat;
		if (wr_stat) begin
			next_stat = (wdata & STAT_WRITE_MASK) | (stat & ~STAT_WRITE_MASK);
			// bank1 flag: firmware may only clear it
			next_stat[BIT_BANK1] = stat[BIT_BANK1] & wdata[BIT_BANK1]; // [RULE17]
		end
		if (evt.bank1_stored && PINGPONG) begin
			next_stat[BIT_BANK1] = 1'b1; // [RULE13]
		end
		if (evt.stall_sent && eff_type != USBEP_ISO) begin
			next_stat[BIT_STALLSENT] = 1'b1; // [RULE19]
		end
	end

	// bus reset restores defaults just like the hardware reset
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl <= CTRL_RST; // [RULE2] [RULE22]
			stat <= 8'h00;
		end else if (ce) begin
			if (bus_reset) begin
				ctrl <= CTRL_RST; // [RULE2]
				stat <= 8'h00;
			end else begin
				ctrl <= next_ctrl;
				stat <= next_stat;
			end
		end
	end

	// view registered so every top output comes from a flip-flop
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			view <= '0;
			irq_evt <= 1'b0;
		end else if (ce) begin
			view.active <= next_ctrl[BIT_ENABLE] | (EP == 3'h0 && bus_reset); // [RULE1]
			view.dir_in <= (next_type != USBEP_CONTROL) & next_ctrl[BIT_DIR]; // [RULE6] [RULE7]
			view.ctrl_dir_in <= (next_type == USBEP_CONTROL) & next_stat[BIT_CTRL_DIR]; // [RULE11]
			view.nak_bank1 <= next_stat[BIT_BANK1] & (next_type != USBEP_ISO); // [RULE15] [RULE16]
			view.stall <= next_stat[BIT_STALL_REQUEST]; // [RULE18]
			view.ep_type <= next_type;
			irq_evt <= ~bus_reset & ((next_stat[BIT_BANK1] & ~stat[BIT_BANK1]) // [RULE14]
				| (next_stat[BIT_STALLSENT] & ~stat[BIT_STALLSENT])); // [RULE19]
		end
	end
endmodule : usbep_slot

// ---- verilog/usbep_regs.sv ----
`timescale 1ns/1ns
// =========================================
// endpoint configuration and status, APB slave
module usbep_regs import usbep_pkg::*; (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic usb_bus_reset,
	input wire logic [2:0] evt_ep,
	input wire usbep_evt_t evt,
	input wire logic [NUM_EP-1:0] ep_int_enable,
	output usbep_view_t [NUM_EP-1:0] ep_view,
	output logic [NUM_EP-1:0] ep_int
);
	// =========================================
	// bus decode
	logic [2:0] endpoint_index;
	logic [NUM_EP-1:0] [7:0] ctrl_q;
	logic [NUM_EP-1:0] [7:0] stat_q;
	logic [NUM_EP-1:0] irq_evt;
	logic bus_reset_s;
	logic setup;
	logic hit;
	logic wr_index;
	logic wr_ctrl_any;
	logic wr_stat_any;

	// bus reset arrives from the line-side reset detector, another domain
	usbep_sync #(.W(1)) u_rst_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.d(usb_bus_reset),
		.q(bus_reset_s)
	);

	assign setup = psel & ~penable;
	assign hit = (paddr == ADDR_INDEX) | (paddr == ADDR_STATUS) | (paddr == ADDR_CONTROL);
	// writes land in the setup cycle's successor: answer is one wait-free access phase
	assign wr_index = psel & penable & pwrite & (paddr == ADDR_INDEX);
	assign wr_ctrl_any = psel & penable & pwrite & (paddr == ADDR_CONTROL);
	assign wr_stat_any = psel & penable & pwrite & (paddr == ADDR_STATUS);

	// =========================================
	// index register; out-of-range values are refused and kept
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			endpoint_index <= 3'h0;
		end else if (ce) begin
			if (bus_reset_s) begin
				endpoint_index <= 3'h0;
			end else if (wr_index && pwdata[7:0] <= {5'h00, MAX_INDEX}) begin
				endpoint_index <= pwdata[2:0]; // [RULE20]
			end
		end
	end

	// =========================================
	// one slot per endpoint
	genvar g;
	generate
		for (g = 0; g < NUM_EP; g++) begin : g_ep
			usbep_slot #(.EP(3'(g))) u_slot ( // [RULE21]
				.clk(clk),
				.sys_rst(sys_rst),
				.ce(ce),
				.bus_reset(bus_reset_s),
				.wr_ctrl(wr_ctrl_any && endpoint_index == 3'(g)), // [RULE20]
				.wr_stat(wr_stat_any && endpoint_index == 3'(g)),
				.wdata(pwdata[7:0]),
				.evt((evt_ep == 3'(g)) ? evt : '0),
				.ctrl(ctrl_q[g]),
				.stat(stat_q[g]),
				.view(ep_view[g]),
				.irq_evt(irq_evt[g])
			);
			// pulse gated by the per-endpoint interrupt enable
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					ep_int[g] <= 1'b0;
				end else if (ce) begin
					ep_int[g] <= irq_evt[g] & ep_int_enable[g]; // [RULE14] [RULE19]
				end
			end
		end
	endgenerate

	// =========================================
	// answer: data registered in setup, ready in access phase
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (ce) begin
			pready <= setup;
			pslverr <= setup & ~hit;
			if (setup && !pwrite) begin
				case (paddr)
					ADDR_INDEX: prdata <= {29'h0, endpoint_index};
					ADDR_CONTROL: prdata <= {24'h0, ctrl_q[endpoint_index]}; // [RULE3]
					ADDR_STATUS: prdata <= {24'h0, stat_q[endpoint_index]};
					default: prdata <= 32'h0000_0000;
				endcase
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end
endmodule : usbep_regs

// ---- tb/usbep_regs_asserts.sv ----
`timescale 1ns/1ns
// ====================
// register bus and endpoint view checks
module usbep_regs_asserts import usbep_pkg::*; (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic [2:0] evt_ep,
	input wire usbep_evt_t evt,
	input wire logic [NUM_EP-1:0] ep_int_enable,
	input wire usbep_view_t [NUM_EP-1:0] ep_view,
	input wire logic [NUM_EP-1:0] ep_int
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	sequence s_setup;
		ce && psel && !penable;
	endsequence
	// bank 1 store on non-iso endpoint four
	sequence s_b1;
		ce && evt.bank1_stored && evt_ep == 3'h4 && ep_view[4].ep_type != USBEP_ISO;
	endsequence
	property p_rdy; s_setup |=> pready; endproperty
	property p_rsv; pready && paddr == ADDR_CONTROL |-> prdata[6:4] == 3'h0; endproperty
	property p_ep0; ep_view[0].ep_type == USBEP_CONTROL; endproperty
	property p_rst; $past(sys_rst) && ce |=> ep_view[0].active; endproperty
	// flag rises at the event edge, the gated pulse is registered one edge later
	property p_int; s_b1 ##0 (ep_int_enable[4] && !ep_view[4].nak_bank1) |-> ##2 ep_int[4]; endproperty
	property p_nak; s_b1 |=> ep_view[4].nak_bank1; endproperty
	property p_iso; ep_view[4].ep_type == USBEP_ISO |-> !ep_view[4].nak_bank1; endproperty
	property p_cdir; ep_view[1].ep_type != USBEP_CONTROL |-> !ep_view[1].ctrl_dir_in; endproperty
	property p_dir; ep_view[1].ep_type == USBEP_CONTROL |-> !ep_view[1].dir_in; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready");
	a_rsv: assert property (p_rsv) else $error("reserved set");
	a_ep0: assert property (p_ep0) else $error("ep0 type");
	a_rst: assert property (p_rst) else $error("ep0 off");
	a_int: assert property (p_int) else $error("no irq");
	a_nak: assert property (p_nak) else $error("no nak");
	a_iso: assert property (p_iso) else $error("iso nak");
	a_cdir: assert property (p_cdir) else $error("ctrl dir");
	a_dir: assert property (p_dir) else $error("dir used");
endmodule : usbep_regs_asserts
bind usbep_regs usbep_regs_asserts u_chk (.clk(clk), .sys_rst(sys_rst), .ce(ce), .psel(psel),
	.penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .evt_ep(evt_ep),
	.evt(evt), .ep_int_enable(ep_int_enable), .ep_view(ep_view), .ep_int(ep_int));

// ---- tb/usbep_host_model.sv ----
`timescale 1ns/1ns
// ====================
// host traffic as seen through the serial engine
module usbep_host_model import usbep_pkg::*; (
	input wire logic clk,
	output logic [2:0] evt_ep,
	output usbep_evt_t evt
);
	// idle at time zero
	initial begin
		evt_ep = 3'h0;
		evt = '0;
	end
	// gap must be nonzero so two posts never collide in one step
	task post(input logic [2:0] e, input usbep_evt_t v, input int gap);
		repeat (gap) @(posedge clk);
		evt_ep <= e;
		evt <= v;
		@(posedge clk);
		evt_ep <= ~e; // stale index scrambled once idle
		evt <= '0;
	endtask : post
endmodule : usbep_host_model

// ---- tb/usb_endpoint_config_status_bench.sv ----
`timescale 1ns/1ns
module usb_endpoint_config_status_bench import usbep_pkg::*; ;
	logic clk = 0, sys_rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0, usb_bus_reset = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er;
	logic [2:0] evt_ep;
	usbep_evt_t evt;
	logic [NUM_EP-1:0] ep_int_enable = '1;
	usbep_view_t [NUM_EP-1:0] ep_view;
	logic [NUM_EP-1:0] ep_int;
	int bad_count = 0, n_tests = 0;
	// rows: address, op (1 write, 0 read, 2 expect error), write data, expected
	logic [27:0] rows [10] = '{28'hd4_0_00_80, 28'hc7_1_01_00, 28'hd4_0_00_00, 28'hd4_1_fe_00,
		28'hd4_0_00_86, 28'hc7_1_07_00, 28'hd4_0_00_86, 28'hc7_1_00_00, 28'hce_0_00_00, 28'h10_2_00_01};
	usbep_regs u_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .usb_bus_reset(usb_bus_reset), .evt_ep(evt_ep), .evt(evt),
		.ep_int_enable(ep_int_enable), .ep_view(ep_view), .ep_int(ep_int));
	usbep_host_model u_host (.clk(clk), .evt_ep(evt_ep), .evt(evt));
	initial forever #5 clk = ~clk;
	task finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	task chk(input logic [7:0] g, input logic [7:0] x);
		n_tests++;
		if (g !== x) begin
			bad_count++;
			$display("unexpected at %0t got %h want %h", $time, g, x);
		end
	endtask : chk
	// one transfer; held until ready is seen at an edge
	task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (pready !== 1'b1 && i < 40);
		if (i == 40) begin
			bad_count++;
			finish_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task rdc(input logic [7:0] a, input logic [7:0] x);
		apb(1'b0, a, 8'h00);
		chk(rd[7:0], x);
	endtask : rdc
	// ====================
	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		foreach (rows[k]) begin
			apb(rows[k][19:16] == 4'h1, rows[k][27:20], rows[k][15:8]);
			if (rows[k][19:16] == 4'h2)
				chk({7'h0, er}, rows[k][7:0]);
			else if (rows[k][19:16] == 4'h0)
				chk(rd[7:0], rows[k][7:0]);
		end
		wr(ADDR_INDEX, 8'h01);
		u_host.post(3'h1, 4'b1000, 1);
		rdc(ADDR_CONTROL, 8'h8e);
		u_host.post(3'h1, 4'b0100, 3);
		rdc(ADDR_CONTROL, 8'h86);
		for (int t = 0; t < 4; t++) begin
			wr(ADDR_CONTROL, 8'h84 | t[7:0]);
			@(posedge clk);
			chk({6'h0, ep_view[1].ep_type}, t[7:0]);
			chk({7'h0, ep_view[1].dir_in}, {7'h0, t != 0});
			chk({7'h0, ep_view[1].active}, 8'h01);
		end
		wr(ADDR_CONTROL, 8'h02);
		wr(ADDR_STATUS, 8'h80);
		wr(ADDR_INDEX, 8'h00);
		wr(ADDR_STATUS, 8'h80);
		wr(ADDR_CONTROL, 8'h83);
		@(posedge clk);
		chk({7'h0, ep_view[1].active}, 8'h00);
		chk({7'h0, ep_view[1].ctrl_dir_in}, 8'h00);
		chk({7'h0, ep_view[0].ctrl_dir_in}, 8'h01);
		chk({6'h0, ep_view[0].ep_type}, 8'h00);
		wr(ADDR_STATUS, 8'h00);
		wr(ADDR_INDEX, 8'h04);
		wr(ADDR_CONTROL, 8'h82);
		u_host.post(3'h4, 4'b0010, 1);
		// the interrupt pulse follows the flag by one edge and stands one cycle
		repeat (2) @(posedge clk);
		chk({1'b0, ep_int}, 8'h10);
		rdc(ADDR_STATUS, 8'h40);
		chk({7'h0, ep_view[4].nak_bank1}, 8'h01);
		wr(ADDR_STATUS, 8'h00);
		rdc(ADDR_STATUS, 8'h00);
		wr(ADDR_CONTROL, 8'h81);
		u_host.post(3'h4, 4'b0010, 1);
		@(posedge clk);
		chk({7'h0, ep_view[4].nak_bank1}, 8'h00);
		wr(ADDR_CONTROL, 8'h82);
		wr(ADDR_STATUS, 8'h20);
		@(posedge clk);
		chk({7'h0, ep_view[4].stall}, 8'h01);
		// endpoint four's interrupt masked: the flag still sets, no pulse
		ep_int_enable <= 7'h6f;
		u_host.post(3'h4, 4'b0001, 2);
		repeat (2) @(posedge clk);
		chk({1'b0, ep_int}, 8'h00);
		ep_int_enable <= '1;
		rdc(ADDR_STATUS, 8'h28);
		usb_bus_reset <= 1'b1;
		repeat (6) @(posedge clk);
		usb_bus_reset <= 1'b0;
		repeat (4) @(posedge clk);
		rdc(ADDR_CONTROL, 8'h80);
		rdc(ADDR_INDEX, 8'h00);
		wr(ADDR_INDEX, 8'h04);
		rdc(ADDR_CONTROL, 8'h00);
		finish_test();
	end
endmodule : usb_endpoint_config_status_bench
